// ===== rtl/vic_core.sv
// Vectored interrupt controller with exception stacking sequencer
// Operation
// - Vector entries hold low sixteen handler bits
// - Only control modes 0 and 2 exist
// - Mode 0: fixed order, global mask flag
// - Mode 2: eight levels, three-bit mask level
// - Request forwarded only while enable bit set
// - Mode 0 masked: only non-maskable accepted
// - Highest priority wins, others stay pending
// - Handling starts after current instruction completes
// - Mode 0 stacks return address and condition codes
// - Mode 0 sets global mask after stacking
// - Fetch vector entry and jump to handler
// - Mode 2 ties broken by default order
// - Mode 2 accepts only level above mask
// - Mode 2 also stacks extended control register
// - Mode 2 clears trace flag after stacking
// - Mask level takes accepted level, non-maskable seven
// - Lower vector number means higher default priority
// - Non-maskable always accepted, highest priority
`timescale 1ns/1ps

module vic_core
    import vic_pkg::*;
#(
    parameter int NUM_SRC = MAX_SRC                     // Number of maskable sources
) (
    input  wire logic                core_clk_i,
    input  wire logic                srst_i,
    // Register port
    input  wire logic [ADDR_W-1:0]   reg_addr_i,
    input  wire logic [DATA_W-1:0]   reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic      [DATA_W-1:0]   reg_rdata_o,
    // Sources
    input  wire logic [NUM_SRC-1:0]  src_req_i,
    output logic      [NUM_SRC-1:0]  src_ack_o,
    input  wire logic                nmi_i,
    output logic                     nmi_ack_o,
    // CPU core side
    input  wire logic                insn_done_i,
    input  wire logic [15:0]         next_pc_i,
    output logic                     stk_we_o,
    output logic      [15:0]         stk_addr_o,
    output logic      [15:0]         stk_data_o,
    output logic                     vec_rd_o,
    output logic      [15:0]         vec_addr_o,
    input  wire logic                vec_valid_i,
    input  wire logic [15:0]         vec_data_i,
    output logic                     jump_o,
    output logic      [15:0]         jump_addr_o,
    // Interrupt to system
    output logic                     irq_o
);

    // ==========================================================
    // Elaboration check
    // Refused at elaboration: the winner index and vector table cover at most MAX_SRC sources
    if (NUM_SRC < 1 || NUM_SRC > MAX_SRC) begin : g_num_src_check
        $error("vic_core: NUM_SRC out of range");
    end

    // ==========================================================
    // State
    vic_state_t         state_reg;                      // Sequencer state
    logic [1:0]         mode_reg;                       // Control mode field
    logic [7:0]         ccr_reg;                        // Condition codes
    logic [7:0]         exr_reg;                        // Trace flag and mask level
    logic [NUM_SRC-1:0] en_reg;                         // Source enables
    logic [EVT_W-1:0]   sts_reg;                        // Sticky events
    logic [EVT_W-1:0]   msk_reg;                        // Event mask
    logic [15:0]        sp_reg;                         // Stack pointer
    logic [2:0]         prio_reg [NUM_SRC];             // Priority levels
    logic               nmi_prev_reg;                   // Edge detect history
    logic               nmi_pend_reg;                   // Latched non-maskable request
    logic               win_nmi_reg;                    // Winner is non-maskable
    logic [3:0]         win_idx_reg;                    // Winner index
    logic [2:0]         win_lvl_reg;                    // Winner level
    logic [6:0]         win_vec_reg;                    // Winner vector number
    logic [15:0]        ret_pc_reg;                     // Return address to stack
    logic [DATA_W-1:0]  rdata_reg;

    // ==========================================================
    // Arbitration
    logic               best_found;
    logic [3:0]         best_idx;
    logic [2:0]         best_lvl;
    logic [2:0]         cand_lvl;
    logic               accept_ok;
    logic               accept_go;
    logic               mode2;
    logic [7:0]         prio_ofs;

    assign mode2 = (mode_reg == MODE_LEVELS);

    // Scan upward and replace only on a strictly higher level, so the lowest index wins ties
    always_comb begin
        best_found = 1'b0;
        best_idx   = 4'h0;
        best_lvl   = 3'h0;
        cand_lvl   = 3'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            // Fixed order in mode 0: every source looks alike, index decides
            cand_lvl = mode2 ? prio_reg[i] : 3'h0;
            if (src_req_i[i] && en_reg[i]) begin
                if (!best_found || cand_lvl > best_lvl) begin
                    best_found = 1'b1;
                    best_idx   = 4'(i);
                    best_lvl   = cand_lvl;
                end
            end
        end
    end

    // Non-maskable overrides every mask; otherwise the mode decides
    always_comb begin
        if (nmi_pend_reg) begin
            accept_ok = 1'b1;
        end else if (mode2) begin
            accept_ok = best_found && (best_lvl > exr_reg[2:0]);
        end else begin
            accept_ok = best_found && !ccr_reg[CCR_MASK_BIT];
        end
    end

    assign accept_go = (state_reg == ST_IDLE) && accept_ok;

    // ==========================================================
    // Non-maskable edge latch; a new edge wins over the clear
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            nmi_prev_reg <= 1'b0;
            nmi_pend_reg <= 1'b0;
        end else begin
            nmi_prev_reg <= nmi_i;
            if (nmi_i && !nmi_prev_reg) begin
                nmi_pend_reg <= 1'b1;
            end else if (accept_go) begin
                nmi_pend_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Winner capture and acknowledge pulses
    // Losers are never acknowledged, so they stay asserted at the source
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            win_nmi_reg <= 1'b0;
            win_idx_reg <= 4'h0;
            win_lvl_reg <= 3'h0;
            win_vec_reg <= 7'h00;
            src_ack_o   <= '0;
            nmi_ack_o   <= 1'b0;
        end else begin
            src_ack_o <= '0;
            nmi_ack_o <= 1'b0;
            if (accept_go) begin
                win_nmi_reg <= nmi_pend_reg;
                win_idx_reg <= best_idx;
                win_lvl_reg <= best_lvl;
                // Each source keeps its own fixed vector number
                win_vec_reg <= nmi_pend_reg ? NMI_VEC_NUM : VEC_TAB[best_idx];
                if (nmi_pend_reg) begin
                    nmi_ack_o <= 1'b1;
                end else begin
                    src_ack_o[best_idx] <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Exception sequencer
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE:      if (accept_go) state_reg <= ST_WAIT_INSN;
                ST_WAIT_INSN: if (insn_done_i) state_reg <= ST_PUSH_PC;
                ST_PUSH_PC:   state_reg <= ST_PUSH_CCR;
                // Mode 2 adds a third word to the frame
                ST_PUSH_CCR:  state_reg <= mode2 ? ST_PUSH_EXR : ST_MASK;
                ST_PUSH_EXR:  state_reg <= ST_MASK;
                ST_MASK:      state_reg <= ST_VEC_RD;
                ST_VEC_RD:    state_reg <= ST_VEC_WAIT;
                ST_VEC_WAIT:  if (vec_valid_i) state_reg <= ST_JUMP;
                ST_JUMP:      state_reg <= ST_IDLE;
                default:      state_reg <= ST_IDLE;
            endcase
        end
    end

    // Return address is the next instruction, caught at the boundary
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ret_pc_reg <= 16'h0000;
        end else if (state_reg == ST_WAIT_INSN && insn_done_i) begin
            ret_pc_reg <= next_pc_i;
        end
    end

    // Stack writes, one word per push, pointer pre-decremented
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            stk_we_o   <= 1'b0;
            stk_addr_o <= 16'h0000;
            stk_data_o <= 16'h0000;
        end else begin
            stk_we_o <= 1'b0;
            case (state_reg)
                ST_PUSH_PC: begin
                    stk_we_o   <= 1'b1;
                    stk_addr_o <= sp_reg - STACK_STEP;
                    stk_data_o <= ret_pc_reg;
                end
                ST_PUSH_CCR: begin
                    stk_we_o   <= 1'b1;
                    stk_addr_o <= sp_reg - STACK_STEP;
                    stk_data_o <= {8'h00, ccr_reg};
                end
                ST_PUSH_EXR: begin
                    stk_we_o   <= 1'b1;
                    stk_addr_o <= sp_reg - STACK_STEP;
                    stk_data_o <= {8'h00, exr_reg};
                end
                default: begin
                    stk_we_o <= 1'b0;
                end
            endcase
        end
    end

    // Vector fetch and jump
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            vec_rd_o    <= 1'b0;
            vec_addr_o  <= 16'h0000;
            jump_o      <= 1'b0;
            jump_addr_o <= 16'h0000;
        end else begin
            vec_rd_o <= 1'b0;
            jump_o   <= 1'b0;
            if (state_reg == ST_MASK) begin
                vec_rd_o   <= 1'b1;
                vec_addr_o <= 16'(win_vec_reg) << VEC_SLOT_SHIFT;
            end
            if (state_reg == ST_VEC_WAIT && vec_valid_i) begin
                // Entry holds only the low half of the handler address
                jump_o      <= 1'b1;
                jump_addr_o <= vec_data_i;
            end
        end
    end

    // ==========================================================
    // Register writes
    assign prio_ofs = reg_addr_i - OFS_PRIO_BASE;

    // Mode field: values other than 0 and 2 are ignored
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            mode_reg <= RST_SYS_CTRL[SYS_MODE_LSB +: 2];
        end else if (reg_wr_i && reg_addr_i == OFS_SYS_CTRL) begin
            if (reg_wdata_i[SYS_MODE_LSB +: 2] == MODE_FIXED ||
                reg_wdata_i[SYS_MODE_LSB +: 2] == MODE_LEVELS) begin
                mode_reg <= reg_wdata_i[SYS_MODE_LSB +: 2];
            end
        end
    end

    // Condition and extended control: the sequencer wins over software
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ccr_reg <= RST_COND_CODE;
            exr_reg <= RST_EXT_CTRL;
        end else if (state_reg == ST_MASK) begin
            if (mode2) begin
                exr_reg[EXR_TRACE_BIT] <= 1'b0;
                exr_reg[2:0] <= win_nmi_reg ? MASK_LVL_NMI : win_lvl_reg;
            end else begin
                ccr_reg[CCR_MASK_BIT] <= 1'b1;
            end
        end else if (reg_wr_i) begin
            if (reg_addr_i == OFS_COND_CODE) begin
                ccr_reg <= reg_wdata_i[7:0];
            end
            if (reg_addr_i == OFS_EXT_CTRL) begin
                exr_reg <= {reg_wdata_i[7], 4'h0, reg_wdata_i[2:0]};
            end
        end
    end

    // Stack pointer: moves one word per push, software may reload it
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sp_reg <= RST_STACK_PTR;
        end else if (state_reg == ST_PUSH_PC || state_reg == ST_PUSH_CCR || state_reg == ST_PUSH_EXR) begin
            sp_reg <= sp_reg - STACK_STEP;
        end else if (reg_wr_i && reg_addr_i == OFS_STACK_PTR) begin
            sp_reg <= reg_wdata_i;
        end
    end

    // Enables, event mask, priority levels
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            en_reg  <= '0;
            msk_reg <= '0;
            for (int i = 0; i < NUM_SRC; i++) begin
                prio_reg[i] <= RST_PRIO;
            end
        end else if (reg_wr_i) begin
            if (reg_addr_i == OFS_SRC_ENABLE) begin
                en_reg <= reg_wdata_i[NUM_SRC-1:0];
            end
            if (reg_addr_i == OFS_IRQ_MASK) begin
                msk_reg <= reg_wdata_i[EVT_W-1:0];
            end
            if (reg_addr_i >= OFS_PRIO_BASE && prio_ofs < 8'(NUM_SRC)) begin
                prio_reg[prio_ofs[3:0]] <= reg_wdata_i[2:0];
            end
        end
    end

    // Sticky events: a new event wins over a write-one clear
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            sts_reg <= '0;
        end else begin
            sts_reg <= (sts_reg & ~((reg_wr_i && reg_addr_i == OFS_IRQ_STATUS) ?
                                    reg_wdata_i[EVT_W-1:0] : {EVT_W{1'b0}}))
                     | {accept_go && nmi_pend_reg, accept_go && !nmi_pend_reg};
        end
    end

    assign irq_o = |(sts_reg & msk_reg);

    // ==========================================================
    // Register reads, data one cycle after the strobe, unmapped read zero
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rdata_reg <= '0;
        end else if (reg_rd_i) begin
            rdata_reg <= '0;
            case (reg_addr_i)
                OFS_SYS_CTRL:   rdata_reg[SYS_MODE_LSB +: 2] <= mode_reg;
                OFS_COND_CODE:  rdata_reg[7:0] <= ccr_reg;
                OFS_EXT_CTRL:   rdata_reg[7:0] <= exr_reg;
                OFS_SRC_ENABLE: rdata_reg[NUM_SRC-1:0] <= en_reg;
                OFS_IRQ_STATUS: rdata_reg[EVT_W-1:0] <= sts_reg;
                OFS_IRQ_MASK:   rdata_reg[EVT_W-1:0] <= msk_reg;
                OFS_STACK_PTR:  rdata_reg <= sp_reg;
                default: begin
                    if (reg_addr_i >= OFS_PRIO_BASE && prio_ofs < 8'(NUM_SRC)) begin
                        rdata_reg[2:0] <= prio_reg[prio_ofs[3:0]];
                    end
                end
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ==========================================================
    // Assertions
    a_wait_insn_end: assert property (@(posedge core_clk_i) disable iff (srst_i)
        state_reg == ST_WAIT_INSN && !insn_done_i |=> state_reg == ST_WAIT_INSN)
        else $error("left instruction wait early");

    a_mode0_mask_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
        state_reg == ST_IDLE && !mode2 && ccr_reg[CCR_MASK_BIT] && !nmi_pend_reg |=> state_reg == ST_IDLE)
        else $error("masked request accepted in mode 0");

    a_mode2_level_gt: assert property (@(posedge core_clk_i) disable iff (srst_i)
        accept_go && mode2 && !nmi_pend_reg |-> best_lvl > exr_reg[2:0])
        else $error("level not above mask accepted");

    a_accept_enabled: assert property (@(posedge core_clk_i) disable iff (srst_i)
        accept_go && !nmi_pend_reg |=> $onehot(src_ack_o & en_reg))
        else $error("disabled source acknowledged");

    a_vec_slot_addr: assert property (@(posedge core_clk_i) disable iff (srst_i)
        vec_rd_o |-> vec_addr_o == {7'h00, win_vec_reg, 2'b00})
        else $error("vector address not number times four");

    a_ccr_mask_set: assert property (@(posedge core_clk_i) disable iff (srst_i)
        state_reg == ST_MASK && !mode2 |=> ccr_reg[CCR_MASK_BIT] && vec_rd_o)
        else $error("mask flag not set with vector fetch");

    a_exr_level_load: assert property (@(posedge core_clk_i) disable iff (srst_i)
        state_reg == ST_MASK && mode2 |=>
            !exr_reg[EXR_TRACE_BIT] && exr_reg[2:0] == (win_nmi_reg ? MASK_LVL_NMI : win_lvl_reg))
        else $error("extended control not updated");

    a_nmi_mask_seven: assert property (@(posedge core_clk_i) disable iff (srst_i)
        state_reg == ST_MASK && mode2 && win_nmi_reg |=> exr_reg[2:0] == 3'h7)
        else $error("non-maskable mask level not seven");

    a_frame_depth: assert property (@(posedge core_clk_i) disable iff (srst_i)
        state_reg == ST_WAIT_INSN && insn_done_i && mode2 |=> ##1 stk_we_o [*3] ##1 !stk_we_o)
        else $error("mode 2 frame not three words");

    a_nmi_always: assert property (@(posedge core_clk_i) disable iff (srst_i)
        state_reg == ST_IDLE && nmi_pend_reg |=> nmi_ack_o && state_reg == ST_WAIT_INSN)
        else $error("non-maskable request not accepted");

    a_jump_vector: assert property (@(posedge core_clk_i) disable iff (srst_i)
        state_reg == ST_VEC_WAIT && vec_valid_i |=> jump_o && jump_addr_o == $past(vec_data_i))
        else $error("jump address not vector contents");

endmodule // vic_core

// ===== rtl/vic_pkg.sv
// Constants shared by the vectored interrupt control block
package vic_pkg;

    // ==========================================================
    // Register bus widths
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 16;

    // ==========================================================
    // Register offsets
    localparam logic [7:0]  OFS_SYS_CTRL    = 8'h00;   // System control, mode field
    localparam logic [7:0]  OFS_COND_CODE   = 8'h01;   // Condition code register
    localparam logic [7:0]  OFS_EXT_CTRL    = 8'h02;   // Extended control register
    localparam logic [7:0]  OFS_SRC_ENABLE  = 8'h03;   // Per-source request enables
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h04;   // Sticky events, write one to clear
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h05;   // Event mask
    localparam logic [7:0]  OFS_STACK_PTR   = 8'h06;   // Stack pointer for stacking
    localparam logic [7:0]  OFS_PRIO_BASE   = 8'h10;   // First priority level register

    // ==========================================================
    // Field positions
    localparam int          SYS_MODE_LSB    = 4;       // Two-bit control mode field
    localparam int          CCR_MASK_BIT    = 7;       // Global mask flag
    localparam int          EXR_TRACE_BIT   = 7;       // Trace flag
    localparam int          EVT_ACCEPT_BIT  = 0;       // Maskable source accepted
    localparam int          EVT_NMI_BIT     = 1;       // Non-maskable source accepted
    localparam int          EVT_W           = 2;

    // ==========================================================
    // Control modes and special values
    localparam logic [1:0]  MODE_FIXED      = 2'h0;
    localparam logic [1:0]  MODE_LEVELS     = 2'h2;
    localparam logic [2:0]  MASK_LVL_NMI    = 3'h7;
    localparam logic [6:0]  NMI_VEC_NUM     = 7'h07;
    localparam int          VEC_SLOT_SHIFT  = 2;       // Four bytes per vector slot
    localparam logic [15:0] STACK_STEP      = 16'h0002;

    // ==========================================================
    // Values after reset
    localparam logic [15:0] RST_SYS_CTRL    = 16'h0000;
    localparam logic [7:0]  RST_COND_CODE   = 8'h80;   // Masked out of reset
    localparam logic [7:0]  RST_EXT_CTRL    = 8'h07;
    localparam logic [15:0] RST_STACK_PTR   = 16'h0000;
    localparam logic [2:0]  RST_PRIO        = 3'h7;

    // ==========================================================
    // Source vector numbers, ascending so index order is default priority
    localparam int          MAX_SRC         = 16;
    localparam logic [6:0]  VEC_TAB [0:MAX_SRC-1] = '{
        7'h30, 7'h31, 7'h32, 7'h33, 7'h34, 7'h38, 7'h39, 7'h3a,
        7'h3b, 7'h3c, 7'h50, 7'h51, 7'h52, 7'h53, 7'h68, 7'h7c
    };

    // Exception sequencer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_WAIT_INSN, ST_PUSH_PC, ST_PUSH_CCR, ST_PUSH_EXR,
        ST_MASK, ST_VEC_RD, ST_VEC_WAIT, ST_JUMP
    } vic_state_t;

endpackage : vic_pkg

// ===== sim/vectored_interrupt_control_tb_top.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps

module vectored_interrupt_control_tb_top;
    import vic_pkg::*;
`define CHK(nm, ex, ac) begin n_checks++; if ((ac) !== (ex)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, ex, ac); end end
    logic core_clk_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0, nmi_i = 0;
    logic [7:0]  reg_addr_i = '0;
    logic [15:0] reg_wdata_i = '0, src_req_i = '0, reg_rdata_o, src_ack_o, stk_addr_o, stk_data_o;
    logic [15:0] vec_addr_i_w, vec_data_i, jump_addr_o, next_pc_i, r, ack, va, pc, sa, ja;
    logic nmi_ack_o, insn_done_i, stk_we_o, vec_rd_o, vec_valid_i, jump_o, irq_o, na;
    int miscompares = 0, n_checks = 0, pushes;
    always #12.5 core_clk_i = ~core_clk_i;

    vic_core DUT (.core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .src_req_i(src_req_i),
        .src_ack_o(src_ack_o), .nmi_i(nmi_i), .nmi_ack_o(nmi_ack_o), .insn_done_i(insn_done_i),
        .next_pc_i(next_pc_i), .stk_we_o(stk_we_o), .stk_addr_o(stk_addr_o), .stk_data_o(stk_data_o),
        .vec_rd_o(vec_rd_o), .vec_addr_o(vec_addr_i_w), .vec_valid_i(vec_valid_i), .vec_data_i(vec_data_i),
        .jump_o(jump_o), .jump_addr_o(jump_addr_o), .irq_o(irq_o));
    vic_cpu_model cpu (.core_clk_i(core_clk_i), .srst_i(srst_i), .vec_rd_i(vec_rd_o), .vec_addr_i(vec_addr_i_w),
        .vec_valid_o(vec_valid_i), .vec_data_o(vec_data_i), .insn_done_o(insn_done_i), .next_pc_o(next_pc_i));

    // Sources hold a request until it is acknowledged
    always @(posedge core_clk_i) if (|src_ack_o) src_req_i <= src_req_i & ~src_ack_o;

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk_i); reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d;
        @(posedge core_clk_i); reg_wr_i <= 0;
        // One more edge so the written register has settled before any check
        @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge core_clk_i); reg_rd_i <= 1; reg_addr_i <= a;
        @(posedge core_clk_i); reg_rd_i <= 0;
        @(posedge core_clk_i); d = reg_rdata_o;
    endtask
    // Follows one exception sequence up to the jump, bounded
    task automatic serve;
        ack = '0; na = 0; va = '0; pc = '0; sa = '0; ja = '1; pushes = 0;
        for (int i = 0; i < 80 && ja === '1; i++) begin
            @(posedge core_clk_i);
            if (|src_ack_o) ack = src_ack_o;
            if (nmi_ack_o) na = 1;
            if (vec_rd_o) va = vec_addr_i_w;
            if (stk_we_o && pushes++ == 0) begin pc = stk_data_o; sa = stk_addr_o; end
            if (jump_o) ja = jump_addr_o;
        end
        `CHK("jump address", va ^ 16'h5a00, ja)
        `CHK("stacked pc", 16'h1234, pc)
    endtask

    task automatic t_reset_nmi;
        rd(OFS_COND_CODE, r); `CHK("ccr reset", 16'h0080, r)
        rd(OFS_EXT_CTRL, r); `CHK("exr reset", 16'h0007, r)
        rd(8'h0f, r); `CHK("unmapped", 16'h0000, r)
        wr(OFS_SRC_ENABLE, 16'h0001); src_req_i <= 16'h0001; wr(OFS_IRQ_MASK, 16'h0003);
        repeat (20) @(posedge core_clk_i);
        rd(OFS_IRQ_STATUS, r); `CHK("masked status", 16'h0000, r)
        nmi_i <= 1; serve; nmi_i <= 0;
        `CHK("nmi ack", 1'b1, na)
        `CHK("nmi vector", 16'h001c, va)
        `CHK("first push", 16'hfffe, sa)
        `CHK("pushes mode 0", 2, pushes)
        `CHK("irq raised", 1'b1, irq_o)
        wr(OFS_IRQ_MASK, 16'h0000); `CHK("irq masked", 1'b0, irq_o)
        wr(OFS_IRQ_MASK, 16'h0003); wr(OFS_IRQ_STATUS, 16'h0003); `CHK("irq cleared", 1'b0, irq_o)
        src_req_i <= '0; $display("test reset_nmi done");
    endtask

    task automatic t_mode0;
        wr(OFS_SRC_ENABLE, 16'h0024); src_req_i <= 16'h0024; wr(OFS_COND_CODE, 16'h0000);
        serve; `CHK("winner", 16'h0004, ack)
        `CHK("vector 50", 16'h00c8, va)
        rd(OFS_COND_CODE, r); `CHK("mask set", 16'h0080, r)
        wr(OFS_COND_CODE, 16'h0000); serve;
        `CHK("pending served", 16'h0020, ack)
        `CHK("vector 56", 16'h00e0, va)
        $display("test mode0 done");
    endtask

    task automatic t_mode2;
        wr(OFS_SYS_CTRL, 16'h0010); rd(OFS_SYS_CTRL, r); `CHK("mode 1 ignored", 16'h0000, r)
        wr(OFS_SYS_CTRL, 16'h0020); rd(OFS_SYS_CTRL, r); `CHK("mode 2", 16'h0020, r)
        wr(8'h13, 16'h0005); wr(8'h14, 16'h0005); wr(OFS_EXT_CTRL, 16'h0080);
        wr(OFS_SRC_ENABLE, 16'h0018); src_req_i <= 16'h0018;
        serve; `CHK("tie winner", 16'h0008, ack)
        `CHK("pushes mode 2", 3, pushes)
        rd(OFS_EXT_CTRL, r); `CHK("exr level", 16'h0005, r)
        wr(OFS_IRQ_STATUS, 16'h0003); repeat (20) @(posedge core_clk_i);
        rd(OFS_IRQ_STATUS, r); `CHK("equal level held", 16'h0000, r)
        wr(OFS_EXT_CTRL, 16'h0004); serve;
        `CHK("above mask", 16'h0010, ack)
        nmi_i <= 1; serve; nmi_i <= 0;
        rd(OFS_EXT_CTRL, r); `CHK("nmi level", 16'h0007, r)
        $display("test mode2 done");
    endtask

    task automatic summarize;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge core_clk_i);
        srst_i <= 0;
        t_reset_nmi; t_mode0; t_mode2;
        summarize;
    end
    initial begin
        repeat (5000) @(posedge core_clk_i);
        miscompares++;
        summarize;
    end
endmodule // vectored_interrupt_control_tb_top

// ===== sim/vic_cpu_model.sv
// Behavioural CPU core partner: instruction boundaries, return address and vector table
`timescale 1ns/1ps

module vic_cpu_model
    import vic_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        vec_rd_i,
    input  wire logic [15:0] vec_addr_i,
    output logic             vec_valid_o,
    output logic      [15:0] vec_data_o,
    output logic             insn_done_o,
    output logic      [15:0] next_pc_o
);
    logic [1:0]  cnt_reg;   // Remaining wait cycles of a fetch
    logic        slow_reg;  // Alternates prompt and slow answers
    logic        pend_reg;  // Fetch outstanding
    logic [15:0] addr_reg;  // Address of the outstanding fetch
    logic [1:0]  insn_reg;  // Instruction phase, one instruction per four cycles

    // ==========================================================
    // Fetch sequencing, answer delay toggles so both paths get used
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            {cnt_reg, slow_reg, pend_reg, addr_reg, insn_reg} <= '0;
        end else begin
            insn_reg <= insn_reg + 2'h1;
            if (vec_rd_i) begin
                pend_reg <= 1'b1;
                addr_reg <= vec_addr_i;
                cnt_reg  <= slow_reg ? 2'h3 : 2'h0;
                slow_reg <= ~slow_reg;
            end else if (pend_reg) begin
                if (cnt_reg == 2'h0) pend_reg <= 1'b0;
                else cnt_reg <= cnt_reg - 2'h1;
            end
        end
    end

    // Table entry holds only the low handler bits; data is scrambled when not valid
    assign vec_valid_o = pend_reg && (cnt_reg == 2'h0);
    assign vec_data_o  = vec_valid_o ? (addr_reg ^ 16'h5a00) : ~addr_reg;
    assign insn_done_o = (insn_reg == 2'h3);
    assign next_pc_o   = 16'h1234;
endmodule // vic_cpu_model
